// ===== hdl/pbp_pin_logic.sv
//
// Purpose: port A bit 7 and port B pin logic with a plain register port
// Assumes: compare, address and strobe inputs come from same-clock logic
// Notes:   bit 7 pin input is asynchronous and is synchronised here
//
module pbp_pin_logic
    import pbp_pkg::*;
#(
    parameter int E_DIV = PBP_E_DIV
)
(
    input wire logic clock, // 200 MHz clock
    input wire logic srst, // synchronous reset, active high
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [7:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    output logic portb_read_enable, // internal port B read pulse
    output logic ext_access, // port B access sent to external bus
    input wire logic compare1_match, // compare 1 match pulse
    input wire logic compare1_force, // compare 1 force pulse
    input wire logic [7:0] high_addr, // high-order address byte
    input wire logic address_strobe, // address strobe level
    input wire logic bus_rw, // bus read/write direction
    input wire logic output_strobe_b, // strobe B from handshake logic
    input wire logic porta_bit7_pin_i, // bit 7 pin level
    output logic porta_bit7_pin_o, // bit 7 pin drive value
    output logic porta_bit7_pin_oe, // bit 7 pin drive enable
    output logic [7:0] portb_pins, // port B pin levels
    output logic bus_direction_pin, // shared read/write or strobe pin
    output logic e_clock_out // E clock out
);
    // ************************************************************
    // clock phases
    // ************************************************************
    logic e_level;
    logic e_fall;
    logic ph2_fall;

    pbp_phase_gen #(
        .E_DIV(E_DIV)
    ) u_phase (
        .clock(clock),
        .srst(srst),
        .e_level(e_level),
        .e_fall(e_fall),
        .ph2_fall(ph2_fall)
    );

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    logic pa7_meta_q;
    logic pa7_sync_q;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pa7_meta_q <= 1'b0;
            pa7_sync_q <= 1'b0;
        end
        else
        begin
            pa7_meta_q <= porta_bit7_pin_i;
            pa7_sync_q <= pa7_meta_q;
        end
    end

    // ************************************************************
    // register decode
    // ************************************************************
    logic wr_porta;
    logic wr_portb;
    logic wr_ctrl;
    logic rd_portb;
    logic expanded;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;

    assign expanded = ctrl_q[PBP_CTRL_EXPANDED];
    assign wr_porta = reg_wr && (reg_addr == PBP_ADDR_PORTA);
    assign wr_portb = reg_wr && (reg_addr == PBP_ADDR_PORTB);
    assign wr_ctrl = reg_wr && (reg_addr == PBP_ADDR_CTRL);
    assign rd_portb = reg_rd && (reg_addr == PBP_ADDR_PORTB);

    // only the four defined control bits are kept
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            ctrl_d = reg_wdata & 8'h0f;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctrl_q <= PBP_CTRL_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // ************************************************************
    // port A bit 7
    // ************************************************************
    logic gp_latch_q;
    logic gp_latch_d;
    logic cmp_pend_q;
    logic cmp_pend_d;
    logic out_latch_q;
    logic out_latch_d;
    logic oe_d;
    logic pin_d;

    always_comb
    begin
        gp_latch_d = gp_latch_q;
        if (wr_porta)
        begin
            gp_latch_d = reg_wdata[PBP_PORTA_BIT7];
        end
        // compare events between E edges wait for the next E fall;
        // a new event in the applying cycle is kept, not lost
        cmp_pend_d = cmp_pend_q;
        if (e_fall)
        begin
            cmp_pend_d = 1'b0;
        end
        if (ctrl_q[PBP_CTRL_OC1_SEL] && (compare1_match || compare1_force))
        begin
            cmp_pend_d = 1'b1;
        end
        out_latch_d = out_latch_q;
        if (e_fall)
        begin
            if (!ctrl_q[PBP_CTRL_OC1_SEL])
            begin
                out_latch_d = gp_latch_q;
            end
            else if (cmp_pend_q)
            begin
                out_latch_d = ctrl_q[PBP_CTRL_OC1_DATA];
            end
        end
        oe_d = porta_bit7_pin_oe;
        if (ph2_fall)
        begin
            oe_d = ctrl_q[PBP_CTRL_DIR];
        end
        // drive value is zero while floating so nothing leaks out
        pin_d = out_latch_d & oe_d;
    end

    // phase 2 and E fall never share a cycle, so the output latch and
    // the enable never move in the same clock
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            gp_latch_q <= 1'b0;
            cmp_pend_q <= 1'b0;
            out_latch_q <= 1'b0;
            porta_bit7_pin_oe <= 1'b0;
            porta_bit7_pin_o <= 1'b0;
        end
        else
        begin
            gp_latch_q <= gp_latch_d;
            cmp_pend_q <= cmp_pend_d;
            out_latch_q <= out_latch_d;
            porta_bit7_pin_oe <= oe_d;
            porta_bit7_pin_o <= pin_d;
        end
    end

    // ************************************************************
    // port B
    // ************************************************************
    logic [7:0] pb_pend_q;
    logic [7:0] pb_pend_d;
    logic pb_valid_q;
    logic pb_valid_d;
    logic [7:0] pb_d;
    logic rw_latch_q;
    logic rw_latch_d;
    logic dir_d;

    always_comb
    begin
        pb_pend_d = pb_pend_q;
        pb_valid_d = pb_valid_q;
        pb_d = portb_pins;
        rw_latch_d = rw_latch_q;
        if (ph2_fall)
        begin
            pb_valid_d = 1'b0;
        end
        if (wr_portb && !expanded)
        begin
            pb_pend_d = reg_wdata;
            pb_valid_d = 1'b1;
        end
        if (expanded)
        begin
            // transparent while address strobe is high
            if (address_strobe)
            begin
                pb_d = high_addr;
                rw_latch_d = bus_rw;
            end
        end
        else if (ph2_fall && pb_valid_q)
        begin
            // pins move at mid E-high, away from a read's sample
            pb_d = pb_pend_q;
        end
        dir_d = expanded ? rw_latch_d : output_strobe_b;
    end

    // leaving expanded mode keeps the last address on the pins
    // until the next port B write lands
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pb_pend_q <= PBP_PORTB_RESET;
            pb_valid_q <= 1'b0;
            portb_pins <= PBP_PORTB_RESET;
            rw_latch_q <= 1'b1;
            bus_direction_pin <= 1'b1;
        end
        else
        begin
            pb_pend_q <= pb_pend_d;
            pb_valid_q <= pb_valid_d;
            portb_pins <= pb_d;
            rw_latch_q <= rw_latch_d;
            bus_direction_pin <= dir_d;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] rdata_d;
    logic pbre_d;
    logic ext_d;

    always_comb
    begin
        rdata_d = 8'h00;
        pbre_d = rd_portb && !expanded;
        ext_d = (rd_portb || wr_portb) && expanded;
        if (reg_rd)
        begin
            unique case (reg_addr)
                PBP_ADDR_PORTA:
                begin
                    rdata_d[PBP_PORTA_BIT7] = pa7_sync_q;
                end
                PBP_ADDR_PORTB:
                begin
                    // expanded reads belong to the external bus
                    rdata_d = expanded ? 8'h00 : portb_pins;
                end
                PBP_ADDR_CTRL:
                begin
                    rdata_d = ctrl_q;
                end
                PBP_ADDR_STAT:
                begin
                    rdata_d[PBP_STAT_PIN_OE] = porta_bit7_pin_oe;
                    rdata_d[PBP_STAT_OUT_LATCH] = out_latch_q;
                    rdata_d[PBP_STAT_CMP_PEND] = cmp_pend_q;
                    rdata_d[PBP_STAT_PB_PEND] = pb_valid_q;
                end
                default:
                begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // ************************************************************
    // output registers
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            reg_rdata <= 8'h00;
            portb_read_enable <= 1'b0;
            ext_access <= 1'b0;
            e_clock_out <= 1'b0;
        end
        else
        begin
            reg_rdata <= rdata_d;
            portb_read_enable <= pbre_d;
            ext_access <= ext_d;
            e_clock_out <= e_level;
        end
    end
endmodule : pbp_pin_logic

// ===== include/pbp_pkg.sv
//
// Purpose: constants for the port A bit 7 and port B pin logic
// Assumes: one 200 MHz clock, E and phase 2 derived from it
// Notes:   register offsets are byte addresses on the plain register port
package pbp_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] PBP_ADDR_PORTA = 8'h00;
    localparam logic [7:0] PBP_ADDR_PORTB = 8'h04;
    localparam logic [7:0] PBP_ADDR_CTRL = 8'h08;
    localparam logic [7:0] PBP_ADDR_STAT = 8'h0c;

    // ************************************************************
    // control fields
    // ************************************************************
    localparam int PBP_CTRL_DIR = 0;
    localparam int PBP_CTRL_OC1_SEL = 1;
    localparam int PBP_CTRL_OC1_DATA = 2;
    localparam int PBP_CTRL_EXPANDED = 3;
    localparam int PBP_PORTA_BIT7 = 7;

    // ************************************************************
    // status fields
    // ************************************************************
    localparam int PBP_STAT_PIN_OE = 0;
    localparam int PBP_STAT_OUT_LATCH = 1;
    localparam int PBP_STAT_CMP_PEND = 2;
    localparam int PBP_STAT_PB_PEND = 3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] PBP_CTRL_RESET = 8'h00;
    localparam logic [7:0] PBP_PORTB_RESET = 8'h00;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int PBP_CLOCK_MHZ = 200;
    localparam int PBP_E_MHZ = 25;
    localparam int PBP_E_DIV = PBP_CLOCK_MHZ / PBP_E_MHZ;
endpackage : pbp_pkg

// ===== hdl/pbp_phase_gen.sv
//
// Purpose: E clock and internal phase 2 edge events from one clock
// Assumes: E_DIV is a multiple of four, at least four
// Notes:   all outputs are registered one-cycle pulses or levels
//
module pbp_phase_gen
    import pbp_pkg::*;
#(
    parameter int E_DIV = PBP_E_DIV
)
(
    input wire logic clock, // system clock
    input wire logic srst, // synchronous reset
    output logic e_level, // E clock level
    output logic e_fall, // pulse at E falling edge
    output logic ph2_fall // pulse at mid E-high
);
    localparam int CW = $clog2(E_DIV);
    localparam logic [CW-1:0] LAST = CW'(E_DIV - 1);
    localparam logic [CW-1:0] Q_PH2 = CW'(E_DIV / 4 - 1);
    localparam logic [CW-1:0] Q_EF = CW'(E_DIV / 2 - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic e_d;
    logic ef_d;
    logic pf_d;

    // E is high for the first half of the count; phase 2 falls a
    // quarter period in, so both edges share this domain
    always_comb
    begin
        cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        e_d = (cnt_d < CW'(E_DIV / 2));
        ef_d = (cnt_q == Q_EF);
        pf_d = (cnt_q == Q_PH2);
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cnt_q <= LAST;
            e_level <= 1'b0;
            e_fall <= 1'b0;
            ph2_fall <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            e_level <= e_d;
            e_fall <= ef_d;
            ph2_fall <= pf_d;
        end
    end
endmodule : pbp_phase_gen

// ===== test/pbp_pin_checker.sv
// Purpose: port-level checks for pbp_pin_logic
// Assumes: E_DIV equals the instance value
// Notes: the port mode is tracked from control writes seen on the bus
module pbp_pin_checker
    import pbp_pkg::*;
#(
    parameter int E_DIV = PBP_E_DIV
)
(
    input wire logic clock, // clock
    input wire logic srst, // reset
    input wire logic [7:0] reg_addr, // address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic portb_read_enable, // port b read pulse
    input wire logic ext_access, // external access pulse
    input wire logic [7:0] high_addr, // high address
    input wire logic address_strobe, // address strobe
    input wire logic output_strobe_b, // strobe b
    input wire logic porta_bit7_pin_o, // bit 7 drive
    input wire logic porta_bit7_pin_oe, // bit 7 enable
    input wire logic [7:0] portb_pins, // port b pins
    input wire logic bus_direction_pin, // shared pin
    input wire logic e_clock_out // e clock
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int QTR = E_DIV / 4;
    logic mode_q, mode_d, mode_p_q, e_q, pb_acc;
    logic [7:0] rise_q, rise_d;
    assign pb_acc = (reg_wr || reg_rd) && reg_addr == PBP_ADDR_PORTB;
    // ********************************
    // port mode tracker and E rise distance counter, saturating
    // ********************************
    always_comb
    begin
        mode_d = mode_q;
        if (reg_wr && reg_addr == PBP_ADDR_CTRL)
            mode_d = reg_wdata[PBP_CTRL_EXPANDED];
        if (srst)
            mode_d = 1'b0;
        rise_d = rise_q + {7'h00, rise_q != 8'hff};
        if (e_clock_out && !e_q)
            rise_d = 8'h00;
    end
    always_ff @(posedge clock)
    begin
        mode_q <= mode_d;
        mode_p_q <= mode_q;
        e_q <= e_clock_out;
        rise_q <= rise_d;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    reset_pins_a: assert property (disable iff (1'b0)
        srst |=> portb_pins == 8'h00) else $error("port b not zero");
    idle_read_a: assert property (
        !reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
    efall_pin_a: assert property (
        $changed(porta_bit7_pin_o) && $stable(porta_bit7_pin_oe)
        |-> $fell(e_clock_out)) else $error("bit 7 off e fall");
    ph2_dir_a: assert property (
        $changed(porta_bit7_pin_oe) |-> e_clock_out && int'(rise_q) == QTR - 1)
        else $error("enable off phase 2");
    ph2_portb_a: assert property (
        !mode_q && !mode_p_q && $changed(portb_pins)
        |-> e_clock_out && int'(rise_q) == QTR - 1) else $error("port b late");
    follow_addr_a: assert property (
        mode_q && mode_p_q && address_strobe |=> portb_pins == $past(high_addr))
        else $error("address not passed");
    hold_addr_a: assert property (
        mode_q && mode_p_q && !address_strobe |=> $stable(portb_pins))
        else $error("address not held");
    strobe_pin_a: assert property (
        !mode_q && !mode_p_q |=> bus_direction_pin == $past(output_strobe_b))
        else $error("strobe pin wrong");
    read_en_a: assert property (
        reg_rd && reg_addr == PBP_ADDR_PORTB
        |=> portb_read_enable == !$past(mode_q)) else $error("read enable");
    ext_bus_a: assert property (
        pb_acc |=> ext_access == $past(mode_q)) else $error("external access");
    cover property ($rose(porta_bit7_pin_oe));
    cover property (portb_read_enable);
    cover property (ext_access);
endmodule : pbp_pin_checker

// ===== test/pbp_pin_partner.sv
// Purpose: external circuit on the bit 7 pin
// Assumes: the outside driver is released before the device drives
// Notes: a pull-up holds the line when nobody drives it
module pbp_pin_partner
(
    input wire logic pin_oe, // device drive enable
    input wire logic pin_o, // device drive value
    input wire logic ext_en, // outside driver on
    input wire logic ext_level, // outside level
    output logic pin_wire // resolved pin level
);
    timeunit 1ns;
    timeprecision 100ps;
    assign pin_wire = pin_oe ? pin_o : (ext_en ? ext_level : 1'b1);
endmodule : pbp_pin_partner

// ===== test/tb_porta_bit7_and_portb_pin_logic.sv
// Purpose: directed bench for the bit 7 and port b pin logic
// Assumes: E_DIV of 8, one E period is 8 clocks
// Notes: waits are bounded to two and a half E periods (20 clocks)
module tb_porta_bit7_and_portb_pin_logic
    import pbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, high_addr = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, bus_rw = 1'b0;
    logic compare1_match = 1'b0, compare1_force = 1'b0;
    logic address_strobe = 1'b0, output_strobe_b = 1'b1;
    logic ext_en = 1'b1, ext_level = 1'b0;
    logic pin_wire, pin_o, pin_oe, portb_read_enable, ext_access;
    logic bus_direction_pin, e_clock_out, rd_en, rd_ext;
    logic [7:0] reg_rdata, portb_pins, rd_data;
    int bad_count = 0;
    int check_count = 0;
    always #2.5 clock = ~clock;
    pbp_pin_logic #(.E_DIV(8)) dut (.clock, .srst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .portb_read_enable, .ext_access,
        .compare1_match, .compare1_force, .high_addr, .address_strobe,
        .bus_rw, .output_strobe_b, .porta_bit7_pin_i(pin_wire),
        .porta_bit7_pin_o(pin_o), .porta_bit7_pin_oe(pin_oe), .portb_pins,
        .bus_direction_pin, .e_clock_out);
    pbp_pin_partner far (.pin_oe, .pin_o, .ext_en, .ext_level, .pin_wire);
    // ********************************
    // bus and compare helpers
    // ********************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic check8(input string name, input logic [7:0] e, g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : check8
    task automatic wr(input logic [7:0] a, d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : wr
    // sampled before the edge's updates land, so the value is settled
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        rd_data = reg_rdata;
        rd_en = portb_read_enable;
        rd_ext = ext_access;
    endtask : rd
    task automatic wait_pb(input logic [7:0] v);
        for (int i = 0; i < 20 && portb_pins !== v; i++)
            @(posedge clock);
        check8("portb_pins", v, portb_pins);
    endtask : wait_pb
    task automatic wait_a7(input logic v);
        for (int i = 0; i < 20 && pin_o !== v; i++)
            @(posedge clock);
        check8("bit7 pin", {7'h00, v}, {7'h00, pin_o});
    endtask : wait_a7
    task automatic hold_a7(input logic v);
        repeat (16) @(posedge clock);
        check8("bit7 held", {7'h00, v}, {7'h00, pin_o});
    endtask : hold_a7
    // ********************************
    // scenarios
    // ********************************
    task automatic t_porta();
        check8("portb reset", 8'h00, portb_pins);
        rd(8'h10);
        check8("unmapped", 8'h00, rd_data);
        wr(PBP_ADDR_PORTA, 8'h80);
        repeat (4) @(posedge clock);
        rd(PBP_ADDR_PORTA);
        check8("read pin low", 8'h00, rd_data & 8'h80);
        ext_level <= 1'b1;
        repeat (4) @(posedge clock);
        rd(PBP_ADDR_PORTA);
        check8("read pin high", 8'h80, rd_data & 8'h80);
        check8("input floats", 8'h00, {7'h00, pin_oe});
    endtask : t_porta
    task automatic t_bit7();
        ext_en <= 1'b0;
        wr(PBP_ADDR_PORTA, 8'h00);
        wr(PBP_ADDR_CTRL, 8'h01);
        for (int i = 0; i < 20 && pin_oe !== 1'b1; i++)
            @(posedge clock);
        check8("enable", 8'h01, {7'h00, pin_oe});
        wait_a7(1'b0);
        repeat (4) @(posedge clock);
        rd(PBP_ADDR_PORTA);
        check8("driven low", 8'h00, rd_data & 8'h80);
        wr(PBP_ADDR_PORTA, 8'h80);
        wait_a7(1'b1);
        wr(PBP_ADDR_CTRL, 8'h03);
        wr(PBP_ADDR_PORTA, 8'h00);
        hold_a7(1'b1);
        rd(PBP_ADDR_STAT);
        check8("status", 8'h03, rd_data);
        compare1_match <= 1'b1;
        @(posedge clock);
        compare1_match <= 1'b0;
        wait_a7(1'b0);
        wr(PBP_ADDR_CTRL, 8'h07);
        hold_a7(1'b0);
        compare1_force <= 1'b1;
        @(posedge clock);
        compare1_force <= 1'b0;
        wait_a7(1'b1);
        wr(PBP_ADDR_CTRL, 8'h05);
        wait_a7(1'b0);
        compare1_force <= 1'b1;
        @(posedge clock);
        compare1_force <= 1'b0;
        hold_a7(1'b0);
    endtask : t_bit7
    task automatic t_portb();
        wr(PBP_ADDR_PORTB, 8'ha5);
        wait_pb(8'ha5);
        rd(PBP_ADDR_PORTB);
        check8("portb read", 8'ha5, rd_data);
        check8("read enable", 8'h01, {7'h00, rd_en});
        output_strobe_b <= 1'b0;
        repeat (3) @(posedge clock);
        check8("strobe pin", 8'h00, {7'h00, bus_direction_pin});
    endtask : t_portb
    task automatic t_expanded();
        high_addr <= 8'h5a;
        address_strobe <= 1'b1;
        bus_rw <= 1'b0;
        output_strobe_b <= 1'b1;
        wr(PBP_ADDR_CTRL, 8'h08);
        wait_pb(8'h5a);
        address_strobe <= 1'b0;
        @(posedge clock);
        high_addr <= 8'h11;
        bus_rw <= 1'b1;
        wr(PBP_ADDR_PORTB, 8'h00);
        check8("held address", 8'h5a, portb_pins);
        rd(PBP_ADDR_PORTB);
        check8("external read", 8'h00, rd_data);
        check8("no read enable", 8'h00, {7'h00, rd_en});
        check8("external flag", 8'h01, {7'h00, rd_ext});
        check8("rw pin", 8'h00, {7'h00, bus_direction_pin});
    endtask : t_expanded
    initial
    begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        t_porta();
        t_bit7();
        t_portb();
        t_expanded();
        summarize();
    end
    initial
    begin
        #20000;
        bad_count++;
        summarize();
    end
endmodule : tb_porta_bit7_and_portb_pin_logic
bind pbp_pin_logic pbp_pin_checker #(.E_DIV(E_DIV)) chk (.clock, .srst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .portb_read_enable,
    .ext_access, .high_addr, .address_strobe, .output_strobe_b,
    .porta_bit7_pin_o, .porta_bit7_pin_oe, .portb_pins, .bus_direction_pin,
    .e_clock_out);
